// ### pkg/sar_adc_map.svh
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH
`define RES_BITS 18
`define CLK_PERIOD_NS 50
`define CONV_TIME_MIN_NS 1000
`define CONV_CYC ((`CONV_TIME_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAR_HALF_SCALE 18'h20000
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_RESULT 5'h08
`define REG_IRQ_STATUS 5'h0c
`define REG_IRQ_MASK 5'h10
`define CTRL_SOFT_START 0
`define IRQ_CONV_DONE 0
`define IRQ_READ_DONE 1
`define IRQ_BITS 2
`define IRQ_MASK_RESET 2'h0
// pin synchroniser reset: enable pin at its released (high) level, others low
`define PIN_SYNC_RESET 4'h2
`endif

// ### pkg/sar_adc_pkg.sv
package sar_adc_pkg;
	typedef enum logic {
		ST_ACQUIRE,
		ST_CONVERT
	} conv_state_t;

	typedef struct packed {
		logic convert;
		logic sck;
		logic shared_pin;
		logic daisy_mode;
	} link_in_t;
endpackage

// ### hw/sar_adc_serial_readout.sv
`timescale 1ns/1ps
`include "sar_adc_map.svh"

// Overview of operation
// [RULE1] convert_start rising edge wakes the core and starts converting the held sample.
// [RULE2] core alternates acquisition (tracking) and conversion starting at that edge.
// [RULE3] 18-step binary search from half scale down to the last step.
// [RULE4] conversion is timed internally; no host clock is needed for it.
// [RULE5] busy rises when a conversion starts and falls when it completes.
// [RULE6] at conversion end the 18-bit result is loaded into the serial path.
// [RULE7] up to 500ksps with no latency; result readable before the next conversion.
// [RULE8] core naps automatically between conversions without any host command.
// [RULE9] mode select low: shared pin is an output enable for serial data.
// [RULE10] mode select high: shared pin is serial input from an upstream converter.
// [RULE11] while enabled, data shifts out on each rising sck edge, MSB first.
// [RULE12] serial output carries own result or, in chain mode, passed-through data.
// [RULE13] result is two's complement over 2 to the 18th levels.
// [RULE14] first result bit is valid on the output right after busy falls.
// [RULE15] normal mode: enable low drives output, enable high releases it.
// [RULE16] host may clock sck up to 100MHz with rising edge capture; here sck is sampled on the 50 ns clk_sys, so it must run far slower.
// [RULE17] host gives 18 sck rises per converter per conversion.
// [RULE18] chain mode: after own 18 bits, input bits pass through in order.
module sar_adc_serial_readout (
	// system
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// avalon-mm slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	// converter pins
	input wire logic convert_start_i,
	input wire logic daisy_mode_select_i,
	input wire logic shared_enable_or_serial_in_i,
	input wire logic sck_i,
	output logic busy_o,
	output logic sdo_o,
	output logic sdo_oe_o,
	// analog core
	input wire logic comparator_i,
	output logic [17:0] sampling_cap_array_o,
	output logic track_o,
	output logic nap_o
);
	localparam logic [4:0] CONV_CYC = 5'(`CONV_CYC);
	localparam logic [4:0] LAST_STEP = 5'(`RES_BITS - 1);

	// two-flop synchronisers, third stage only for edge detection
	sar_adc_pkg::link_in_t sync1_q;
	sar_adc_pkg::link_in_t sync2_q;
	sar_adc_pkg::link_in_t sync3_q;
	sar_adc_pkg::link_in_t pins;
	assign pins.convert = convert_start_i;
	assign pins.sck = sck_i;
	assign pins.shared_pin = shared_enable_or_serial_in_i;
	assign pins.daisy_mode = daisy_mode_select_i;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			// enable seen as released, so the output stays off through reset
			sync1_q <= `PIN_SYNC_RESET;
			sync2_q <= `PIN_SYNC_RESET;
			sync3_q <= `PIN_SYNC_RESET;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	wire conv_edge = sync2_q.convert & ~sync3_q.convert;
	wire sck_rise = sync2_q.sck & ~sync3_q.sck;
	wire daisy = sync2_q.daisy_mode;
	wire serial_in = daisy ? sync2_q.shared_pin : 1'b0; // [RULE10]
	wire read_low_enable = sync2_q.shared_pin;

	// bus side
	logic ack_q;
	logic [31:0] readdata_q;
	logic soft_start_q;
	logic [`IRQ_BITS-1:0] irq_status_q;
	logic [`IRQ_BITS-1:0] irq_mask_q;
	logic [17:0] result_q;
	logic [4:0] bits_out_q;

	wire bus_req = avs_read_i | avs_write_i;
	wire wr_take = avs_write_i & ack_q;
	wire sel_ctrl = avs_address_i == `REG_CTRL;
	wire sel_status = avs_address_i == `REG_STATUS;
	wire sel_result = avs_address_i == `REG_RESULT;
	wire sel_irq_status = avs_address_i == `REG_IRQ_STATUS;
	wire sel_irq_mask = avs_address_i == `REG_IRQ_MASK;

	// conversion engine
	sar_adc_pkg::conv_state_t state_q;
	sar_adc_pkg::conv_state_t state_d;
	logic [17:0] sar_q;
	logic [17:0] sar_d;
	logic [4:0] step_q;
	logic [4:0] step_d;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic searching_q;
	logic searching_d;
	logic done_pulse;
	logic [17:0] shift_q;

	// a start from software behaves like a pin edge; both ignored mid-conversion
	wire start = conv_edge | soft_start_q;
	wire [17:0] step_bit = 18'(18'h1 << step_q);
	wire [17:0] next_bit = (step_q == 5'h0) ? 18'h0 : 18'(18'h1 << (step_q - 5'h1));
	// offset binary from the search, MSB flipped gives two's complement
	wire [17:0] twos_result = {~sar_q[17], sar_q[16:0]}; // [RULE13]

	always_comb begin
		state_d = state_q;
		sar_d = sar_q;
		step_d = step_q;
		cnt_d = cnt_q;
		searching_d = searching_q;
		done_pulse = 1'b0;
		case (state_q)
			sar_adc_pkg::ST_ACQUIRE: begin
				if (start) begin // [RULE1]
					state_d = sar_adc_pkg::ST_CONVERT; // [RULE2]
					sar_d = `SAR_HALF_SCALE; // [RULE3]
					step_d = LAST_STEP;
					cnt_d = 5'h0;
					searching_d = 1'b1;
				end
			end
			sar_adc_pkg::ST_CONVERT: begin
				cnt_d = cnt_q + 5'h1; // [RULE4]
				if (searching_q) begin
					// keep or drop the trial bit, then try the next weight
					sar_d = (comparator_i ? sar_q : (sar_q & ~step_bit)) | next_bit; // [RULE3]
					if (step_q == 5'h0) begin
						searching_d = 1'b0;
					end else begin
						step_d = step_q - 5'h1;
					end
				end else if (cnt_q >= CONV_CYC - 5'h1) begin
					state_d = sar_adc_pkg::ST_ACQUIRE; // [RULE2]
					done_pulse = 1'b1;
				end
			end
			default: begin
				state_d = sar_adc_pkg::ST_ACQUIRE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_q <= sar_adc_pkg::ST_ACQUIRE;
			sar_q <= 18'h0;
			step_q <= 5'h0;
			cnt_q <= 5'h0;
			searching_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sar_q <= sar_d;
			step_q <= step_d;
			cnt_q <= cnt_d;
			searching_q <= searching_d;
		end
	end

	assign busy_o = state_q == sar_adc_pkg::ST_CONVERT; // [RULE5]
	assign track_o = state_q == sar_adc_pkg::ST_ACQUIRE;
	assign nap_o = state_q == sar_adc_pkg::ST_ACQUIRE; // [RULE8]
	assign sampling_cap_array_o = sar_q;

	// serial path: sck is slow against clk_sys, so edges are found by sampling
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			shift_q <= 18'h0;
			result_q <= 18'h0;
			bits_out_q <= 5'h0;
		end else if (done_pulse) begin
			shift_q <= twos_result; // [RULE6] [RULE7] [RULE14]
			result_q <= twos_result;
			bits_out_q <= 5'h0;
		end else if (sck_rise && !busy_o) begin
			shift_q <= {shift_q[16:0], serial_in}; // [RULE11] [RULE12] [RULE18]
			if (bits_out_q != 5'(`RES_BITS)) begin
				bits_out_q <= bits_out_q + 5'h1;
			end
		end
	end

	assign sdo_o = shift_q[17]; // [RULE11]
	assign sdo_oe_o = daisy | ~read_low_enable; // [RULE9] [RULE15]
	wire read_done = sck_rise && !busy_o && bits_out_q == LAST_STEP;

	// avalon slave: one wait state on every access
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (avs_read_i && !ack_q) begin
				if (sel_ctrl) begin
					readdata_q <= 32'h0;
				end else if (sel_status) begin
					readdata_q <= {27'h0, bits_out_q == 5'(`RES_BITS), nap_o, sdo_oe_o,
						daisy, busy_o};
				end else if (sel_result) begin
					readdata_q <= {14'h0, result_q};
				end else if (sel_irq_status) begin
					readdata_q <= {30'h0, irq_status_q};
				end else if (sel_irq_mask) begin
					readdata_q <= {30'h0, irq_mask_q};
				end else begin
					readdata_q <= 32'h0;
				end
			end
		end
	end

	assign avs_waitrequest_o = bus_req & ~ack_q;
	assign avs_readdata_o = readdata_q;

	wire [`IRQ_BITS-1:0] irq_set = {read_done, done_pulse};
	wire [`IRQ_BITS-1:0] irq_clr = (wr_take && sel_irq_status) ?
		avs_writedata_i[`IRQ_BITS-1:0] : 2'h0;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			soft_start_q <= 1'b0;
			irq_status_q <= 2'h0;
			irq_mask_q <= `IRQ_MASK_RESET;
		end else begin
			soft_start_q <= wr_take & sel_ctrl & avs_writedata_i[`CTRL_SOFT_START];
			// a new event in the clearing cycle survives
			irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
			if (wr_take && sel_irq_mask) begin
				irq_mask_q <= avs_writedata_i[`IRQ_BITS-1:0];
			end
		end
	end

	assign irq_o = |(irq_status_q & irq_mask_q);

	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	sequence s_start;
		!busy_o && start;
	endsequence
	sequence s_busy_run;
		busy_o [*8];
	endsequence

	a_conv_start_busy: assert property (s_start |=> busy_o) // [RULE1]
		else $error("start did not raise busy");
	a_busy_min_len: assert property (s_start |=> s_busy_run ##0 busy_o [*8]) // [RULE5]
		else $error("busy shorter than conversion time");
	a_busy_bounded: assert property ($rose(busy_o) |-> ##[20:22] !busy_o) // [RULE4]
		else $error("conversion length wrong");
	a_search_start: assert property (s_start |=> sampling_cap_array_o == 18'h20000) // [RULE3]
		else $error("search not at half scale");
	a_result_loaded: assert property ($fell(busy_o) |-> shift_q == result_q
		&& sdo_o == result_q[17]) // [RULE14]
		else $error("result not at serial output");
	a_nap_idle: assert property (nap_o == !busy_o && track_o == nap_o) // [RULE8]
		else $error("nap state wrong");
	a_shift_msb: assert property (sck_rise && !busy_o && !done_pulse |=>
		sdo_o == $past(shift_q[16])) // [RULE11]
		else $error("shift order wrong");
	a_enable_normal: assert property (!daisy |-> sdo_oe_o == !read_low_enable) // [RULE15]
		else $error("output enable wrong in normal mode");
	a_daisy_drive: assert property (daisy |-> sdo_oe_o) // [RULE10]
		else $error("output released in chain mode");
	a_chain_pass: assert property (daisy && sck_rise && !busy_o && !done_pulse |=>
		shift_q[0] == $past(serial_in)) // [RULE18]
		else $error("chain input not captured");
	a_irq_sticky: assert property (done_pulse |=> irq_status_q[0]) // [RULE6]
		else $error("done event lost");
endmodule

// ### bench/host_model.sv
`timescale 1ns/1ps
module host_model (
	// system
	input wire logic clk_i,
	// converter side
	input wire logic sdo_i,
	input wire logic chain_i,
	output logic convert_o,
	output logic sck_o,
	output logic shared_o
);
	logic enable_n_q;
	initial begin
		convert_o = 1'b0;
		// sck stands low outside frames
		sck_o = 1'b0;
		shared_o = 1'b1;
		enable_n_q = 1'b1;
	end
	task automatic set_enable(input logic en_n);
		@(posedge clk_i);
		enable_n_q = en_n;
		shared_o <= en_n;
	endtask
	// held 3 cycles so the synchroniser cannot miss it
	task automatic convert();
		@(posedge clk_i);
		convert_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		convert_o <= 1'b0;
	endtask
	// 400 ns sck period (4 low, 4 high), far below the fastest allowed rate
	task automatic xfer(input int n, input logic [35:0] din, output logic [35:0] dout);
		dout = '0;
		@(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			shared_o <= chain_i ? din[n-1-i] : enable_n_q;
			repeat (3) @(posedge clk_i);
			// bit is captured just before the rising edge that moves it on
			@(negedge clk_i);
			dout[n-1-i] = sdo_i;
			@(posedge clk_i);
			sck_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b0;
		end
		@(posedge clk_i);
		shared_o <= enable_n_q;
	endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
`include "sar_adc_map.svh"
module testbench;
	typedef struct packed {
		logic [17:0] sample;
		logic chain;
		logic [17:0] up;
		logic [17:0] code;
	} row_t;
	logic clk_sys_i, reset_i, rd_q, wr_q, chain_q, wreq, irq, conv_pin, sck, shd, busy, sdo, oe;
	logic track, nap;
	logic [4:0] addr_q;
	logic [31:0] wd_q, rdat, q;
	logic [17:0] trial, sample_q;
	logic [35:0] dout;
	int err_count, checked, n;
	row_t rows [5] = '{'{18'h00000, 1'b0, 18'h00000, 18'h20000},
		'{18'h3ffff, 1'b1, 18'h2a5c3, 18'h1ffff}, '{18'h20000, 1'b0, 18'h00000, 18'h00000},
		'{18'h1ffff, 1'b1, 18'h0f00f, 18'h3ffff}, '{18'h12345, 1'b0, 18'h00000, 18'h32345}};
	// comparator keeps a trial bit while the trial code is not above the sample
	wire cmp = (trial <= sample_q);
	sar_adc_serial_readout dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.avs_address_i(addr_q), .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wd_q),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq), .convert_start_i(conv_pin),
		.daisy_mode_select_i(chain_q), .shared_enable_or_serial_in_i(shd), .sck_i(sck),
		.busy_o(busy), .sdo_o(sdo), .sdo_oe_o(oe), .comparator_i(cmp),
		.sampling_cap_array_o(trial), .track_o(track), .nap_o(nap));
	host_model host_u (.clk_i(clk_sys_i), .sdo_i(sdo), .chain_i(chain_q), .convert_o(conv_pin),
		.sck_o(sck), .shared_o(shd));
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic av(input logic [4:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		addr_q <= a;
		wr_q <= w;
		rd_q <= !w;
		wd_q <= d;
		// waitrequest seen at the rising edge itself; only the watchdog ends a hang
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (wreq !== 1'b0);
		q = rdat;
		rd_q <= 1'b0;
		wr_q <= 1'b0;
		chk("wait states", 36'(k), 36'h2);
	endtask
	task automatic wait_busy(input logic lvl);
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (busy !== lvl);
	endtask
	task automatic test_done();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// tests need about 1400 cycles; a wide margin before calling it a hang
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		err_count++;
		test_done();
	end
	initial begin
		reset_i = 1'b1;
		{rd_q, wr_q, chain_q, addr_q, wd_q, sample_q} = '0;
		repeat (20) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk("busy", busy, 1'b0);
		chk("nap", nap, 1'b1);
		chk("oe off", oe, 1'b0);
		av(`REG_IRQ_MASK, 1'b0, 32'h0);
		chk("mask", q, 32'h0);
		av(5'h14, 1'b0, 32'h0);
		chk("unmapped", q, 32'h0);
		av(`REG_IRQ_MASK, 1'b1, 32'h1);
		host_u.set_enable(1'b0);
		foreach (rows[k]) begin
			@(posedge clk_sys_i);
			chain_q <= rows[k].chain;
			sample_q <= rows[k].sample;
			host_u.convert();
			wait_busy(1'b1);
			chk("half scale", trial, `SAR_HALF_SCALE);
			chk("track", track, 1'b0);
			chk("nap busy", nap, 1'b0);
			wait_busy(1'b0);
			chk("conv len", 36'(n), 36'(`CONV_CYC));
			chk("msb", sdo, rows[k].code[17]);
			chk("oe", oe, 1'b1);
			av(`REG_RESULT, 1'b0, 32'h0);
			chk("result", q, {14'h0, rows[k].code});
			chk("irq", irq, 1'b1);
			host_u.xfer(rows[k].chain ? 36 : 18, {rows[k].up, 18'h0}, dout);
			chk("shift", rows[k].chain ? dout[35:18] : dout[17:0], rows[k].code);
			if (rows[k].chain) chk("chain", dout[17:0], rows[k].up);
			av(`REG_STATUS, 1'b0, 32'h0);
			chk("status", q, {27'h0, 3'h7, rows[k].chain, 1'b0});
			av(`REG_IRQ_STATUS, 1'b1, 32'h3);
			@(negedge clk_sys_i);
			chk("irq clear", irq, 1'b0);
		end
		av(`REG_IRQ_MASK, 1'b1, 32'h0);
		host_u.convert();
		wait_busy(1'b1);
		// a second start while busy must be ignored
		host_u.convert();
		wait_busy(1'b0);
		repeat (10) @(negedge clk_sys_i);
		chk("no restart", busy, 1'b0);
		av(`REG_IRQ_STATUS, 1'b0, 32'h0);
		chk("sticky", q[0], 1'b1);
		chk("masked", irq, 1'b0);
		// software start behaves like a pin edge
		av(`REG_CTRL, 1'b1, 32'h1);
		wait_busy(1'b1);
		chk("soft half", trial, `SAR_HALF_SCALE);
		wait_busy(1'b0);
		chk("soft len", 36'(n), 36'(`CONV_CYC));
		av(`REG_RESULT, 1'b0, 32'h0);
		chk("soft result", q, {14'h0, rows[4].code});
		// reset in mid conversion must abort it and clear the flags
		host_u.convert();
		wait_busy(1'b1);
		@(posedge clk_sys_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("reset busy", busy, 1'b0);
		chk("reset sdo", sdo, 1'b0);
		av(`REG_IRQ_STATUS, 1'b0, 32'h0);
		chk("reset flags", q, 32'h0);
		av(`REG_RESULT, 1'b0, 32'h0);
		chk("reset result", q, 32'h0);
		host_u.convert();
		wait_busy(1'b1);
		wait_busy(1'b0);
		chk("after reset len", 36'(n), 36'(`CONV_CYC));
		chk("after reset msb", sdo, rows[4].code[17]);
		host_u.set_enable(1'b1);
		repeat (6) @(negedge clk_sys_i);
		chk("released", oe, 1'b0);
		test_done();
	end
endmodule
